// ---- verilog/timer_buffered_compare_pwm.v ----
// Two-channel 16-bit compare and PWM timer with AXI4-Lite registers
//
// Behaviour
// - Pair link merges channels onto primary pin
// - Last written channel governs after each wrap
// - Linked: channel1 control ignored, pin released
// - Toggle pin at each period wrap unless full duty or a compare match
// - Wrap to compare match sets pulse width
// - Limit 255 undivided gives 256 clocks
// - Compare 128 of 256 gives half duty
// - Compare fires only on exact equality
// - Buffered switch only at period start
// - Mode bits 01 unbuffered, 10 buffered
// - Action bits 10 clear, 11 set
// - No wrap toggle gives zero duty
// - Full duty bit with toggle forces 100%
// - Wrap sets flag, enable gates request
// - Compare sets channel flag, enable gates request
// - Wrap restarts at zero; high write inhibits
// - Divide select 1 to 64, code 7 none
// - Clear bit self-clears; halt set at reset
// - Flag clears by read then write zero
`timescale 1ns/1ps
module timer_buffered_compare_pwm
#(
   parameter ADDR_W = 8
)
(
   input wire sys_clk,
   input wire rst,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output wire primary_channel_pin_out,
   output wire primary_channel_pin_oe,
   output wire secondary_channel_pin_out,
   output wire secondary_channel_pin_oe,
   output wire timer_irq
);
`include "pwm_timer_defs.vh"

   // Write channel holding registers
   reg aw_held;
   reg w_held;
   reg [ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire do_write;
   wire do_read;

   // Timer state
   reg [15:0] count;
   reg [15:0] period_limit;
   reg wrap_inhibit;
   reg wrap_flag;
   reg wrap_armed;
   reg wrap_irq_enable;
   reg counter_halt;
   reg [2:0] clock_divide_select;
   reg counter_clear;
   reg [7:0] ch_ctrl [0:1];
   reg [15:0] ch_cmp [0:1];
   reg [1:0] ch_armed;
   reg [1:0] ch_out;
   reg active_sel;
   reg last_written;
   wire tick;
   wire wrap_now;
   wire [15:0] next_count;
   wire pair_link_select;
   wire [1:0] ch_match;
   wire [1:0] ch_enabled;
   wire [1:0] ch_flag_irq;

   // Write address/data may arrive in either order; each is held until both are present
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_read = s_axi_arvalid & ~s_axi_rvalid;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= `OFS_CH1_COMPARE
               && aw_addr != `OFS_COUNTER) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read path; a read of a control word with its flag set arms the clear
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (do_read)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `OFS_TIMER_CONTROL:
               s_axi_rdata <= {24'h000000, wrap_flag, wrap_irq_enable, counter_halt,
                  2'h0, clock_divide_select};
            `OFS_COUNTER: s_axi_rdata <= {16'h0000, count};
            `OFS_PERIOD_HIGH: s_axi_rdata <= {24'h000000, period_limit[15:8]};
            `OFS_PERIOD_LOW: s_axi_rdata <= {24'h000000, period_limit[7:0]};
            `OFS_CH0_CONTROL: s_axi_rdata <= {24'h000000, ch_ctrl[0]};
            `OFS_CH0_COMPARE: s_axi_rdata <= {16'h0000, ch_cmp[0]};
            `OFS_CH1_CONTROL: s_axi_rdata <= {24'h000000, ch_ctrl[1]};
            `OFS_CH1_COMPARE: s_axi_rdata <= {16'h0000, ch_cmp[1]};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   clock_divider u_divider
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clear(counter_clear),
      .halt(counter_halt),
      .clock_divide_select(clock_divide_select),
      .tick(tick)
   );

   // Counter runs 0..limit inclusive, so limit 255 gives 256 ticks per period
   assign wrap_now = tick & (count == period_limit);
   assign next_count = counter_clear ? 16'h0000 :
      (wrap_now ? 16'h0000 : (tick ? count + 16'h0001 : count));

   always @(posedge sys_clk)
   begin
      if (rst)
         count <= 16'h0000;
      else
         count <= next_count;
   end

   // Timer control, period limit and the overflow flag
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         wrap_irq_enable <= 1'b0;
         counter_halt <= 1'b1;
         clock_divide_select <= `RST_DIV_SEL;
         counter_clear <= 1'b0;
         period_limit <= `RST_PERIOD_LIMIT;
         wrap_inhibit <= 1'b0;
         wrap_flag <= 1'b0;
         wrap_armed <= 1'b0;
      end
      else
      begin
         counter_clear <= 1'b0;
         if (do_write && w_strb[0] && aw_addr == `OFS_TIMER_CONTROL)
         begin
            wrap_irq_enable <= w_data[`BIT_WRAP_IRQ_ENABLE];
            counter_halt <= w_data[`BIT_COUNTER_HALT];
            counter_clear <= w_data[`BIT_COUNTER_CLEAR];
            clock_divide_select <= w_data[`DIV_SEL_MSB:0];
         end
         // High byte write holds off overflow flagging until low byte lands
         if (do_write && w_strb[0] && aw_addr == `OFS_PERIOD_HIGH)
         begin
            period_limit[15:8] <= w_data[7:0];
            wrap_inhibit <= 1'b1;
         end
         if (do_write && w_strb[0] && aw_addr == `OFS_PERIOD_LOW)
         begin
            period_limit[7:0] <= w_data[7:0];
            wrap_inhibit <= 1'b0;
         end
         // A new overflow beats a pending clear and disarms it
         if (wrap_now && !wrap_inhibit)
         begin
            wrap_flag <= 1'b1;
            wrap_armed <= 1'b0;
         end
         else if (do_write && w_strb[0] && aw_addr == `OFS_TIMER_CONTROL)
         begin
            if (wrap_armed && !w_data[`BIT_WRAP_FLAG])
               wrap_flag <= 1'b0;
            wrap_armed <= 1'b0;
         end
         else if (do_read && s_axi_araddr == `OFS_TIMER_CONTROL && wrap_flag)
            wrap_armed <= 1'b1;
      end
   end

   // Linked pair: channel 0 mode-high bit merges both onto the primary pin
   assign pair_link_select = ch_ctrl[0][`BIT_CH_MODE_HI];

   // Buffer select moves only at a wrap or a counter clear, never mid-period
   always @(posedge sys_clk)
   begin
      if (rst || !pair_link_select)
      begin
         active_sel <= 1'b0;
         last_written <= 1'b0;
      end
      else
      begin
         if (do_write && aw_addr == `OFS_CH1_COMPARE && w_strb[1:0] != 2'h0)
            last_written <= 1'b1;
         else if (do_write && aw_addr == `OFS_CH0_COMPARE && w_strb[1:0] != 2'h0)
            last_written <= 1'b0;
         if (wrap_now || counter_clear)
            active_sel <= last_written;
      end
   end

   // Per-channel compare, output and event flag
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1)
      begin : g_chan
         wire [7:0] ctl;
         wire [15:0] cmp_val;
         wire full_duty;
         wire tov;
         wire [ADDR_W-1:0] ctl_ofs;
         wire [ADDR_W-1:0] cmp_ofs;

         assign ctl_ofs = (c == 0) ? `OFS_CH0_CONTROL : `OFS_CH1_CONTROL;
         assign cmp_ofs = (c == 0) ? `OFS_CH0_COMPARE : `OFS_CH1_COMPARE;
         assign ctl = ch_ctrl[c];
         // Linked primary uses whichever buffer is active; secondary sits idle
         assign cmp_val = (c == 0 && pair_link_select && active_sel) ? ch_cmp[1] :
            ch_cmp[c];
         assign ch_enabled[c] = (ctl[`BIT_CH_MODE_HI] | ctl[`BIT_CH_MODE_LO]) &
            ~(c == 1 && pair_link_select);
         // Match only on exact equality as the counter steps into the value
         assign ch_match[c] = ch_enabled[c] & tick & ~counter_clear &
            (next_count == cmp_val);
         assign full_duty = ctl[`BIT_CH_FULL_DUTY];
         assign tov = ctl[`BIT_CH_TOGGLE_ON_WRAP];
         assign ch_flag_irq[c] = ctl[`BIT_CH_EVENT_FLAG] & ctl[`BIT_CH_IRQ_ENABLE];

         // Compare action wins over the wrap toggle, so compare 0 gives 0% duty
         always @(posedge sys_clk)
         begin
            if (rst)
               ch_out[c] <= 1'b0;
            else if (ch_enabled[c])
            begin
               if (full_duty && tov)
                  ch_out[c] <= ~ctl[`BIT_CH_ACTION_LO];
               else if (ch_match[c] && ctl[`BIT_CH_ACTION_HI])
                  ch_out[c] <= ctl[`BIT_CH_ACTION_LO];
               else if (ch_match[c] && ctl[`BIT_CH_ACTION_LO])
                  ch_out[c] <= ~ch_out[c];
               else if (wrap_now && tov)
                  ch_out[c] <= ~ch_out[c];
            end
         end

         // Control word, compare value, flag with read-then-write-zero clear
         always @(posedge sys_clk)
         begin
            if (rst)
            begin
               ch_ctrl[c] <= 8'h00;
               ch_cmp[c] <= 16'h0000;
               ch_armed[c] <= 1'b0;
            end
            else
            begin
               if (do_write && w_strb[0] && aw_addr == ctl_ofs)
               begin
                  // Channel 1 has no mode-high bit; it always reads zero
                  ch_ctrl[c][6:0] <= (c == 1) ? (w_data[6:0] & 7'h5F) : w_data[6:0];
                  if (ch_armed[c] && !w_data[`BIT_CH_EVENT_FLAG] && !ch_match[c])
                     ch_ctrl[c][`BIT_CH_EVENT_FLAG] <= 1'b0;
               end
               if (do_write && aw_addr == cmp_ofs)
               begin
                  if (w_strb[0])
                     ch_cmp[c][7:0] <= w_data[7:0];
                  if (w_strb[1])
                     ch_cmp[c][15:8] <= w_data[15:8];
               end
               if (ch_match[c])
               begin
                  ch_ctrl[c][`BIT_CH_EVENT_FLAG] <= 1'b1;
                  ch_armed[c] <= 1'b0;
               end
               else if (do_write && w_strb[0] && aw_addr == ctl_ofs)
                  ch_armed[c] <= 1'b0;
               else if (do_read && s_axi_araddr == ctl_ofs && ctl[`BIT_CH_EVENT_FLAG])
                  ch_armed[c] <= 1'b1;
            end
         end
      end
   endgenerate

   // Pins: secondary is released as plain I/O while linked
   assign primary_channel_pin_out = ch_out[0];
   assign primary_channel_pin_oe = ch_enabled[0];
   assign secondary_channel_pin_out = ch_out[1];
   assign secondary_channel_pin_oe = ch_enabled[1];

   // One request line for all enabled flags
   assign timer_irq = (wrap_flag & wrap_irq_enable) | (|ch_flag_irq);
endmodule

// ---- verilog/pwm_timer_defs.vh ----
// Register offsets, field positions and reset values of the PWM timer
`ifndef PWM_TIMER_DEFS_VH
`define PWM_TIMER_DEFS_VH

// Register byte addresses
`define OFS_TIMER_CONTROL 8'h00
`define OFS_COUNTER 8'h04
`define OFS_PERIOD_HIGH 8'h08
`define OFS_PERIOD_LOW 8'h0C
`define OFS_CH0_CONTROL 8'h10
`define OFS_CH0_COMPARE 8'h14
`define OFS_CH1_CONTROL 8'h18
`define OFS_CH1_COMPARE 8'h1C

// Timer control fields
`define BIT_WRAP_FLAG 7
`define BIT_WRAP_IRQ_ENABLE 6
`define BIT_COUNTER_HALT 5
`define BIT_COUNTER_CLEAR 4
`define DIV_SEL_MSB 2

// Channel control fields
`define BIT_CH_EVENT_FLAG 7
`define BIT_CH_IRQ_ENABLE 6
`define BIT_CH_MODE_HI 5
`define BIT_CH_MODE_LO 4
`define BIT_CH_ACTION_HI 3
`define BIT_CH_ACTION_LO 2
`define BIT_CH_TOGGLE_ON_WRAP 1
`define BIT_CH_FULL_DUTY 0

// Reset values and the no-output divide code
`define RST_PERIOD_LIMIT 16'hFFFF
`define RST_DIV_SEL 3'h0
`define DIV_SEL_NONE 3'h7

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/clock_divider.v ----
// Prescaler that turns the bus clock into one-cycle timer tick pulses
`timescale 1ns/1ps
module clock_divider
(
   input wire sys_clk,
   input wire rst,
   input wire clear,
   input wire halt,
   input wire [2:0] clock_divide_select,
   output wire tick
);
`include "pwm_timer_defs.vh"

   reg [5:0] div_count;
   wire [5:0] div_mask;

   // Mask of low bits that must all be one for a tick; divide by 2^select
   assign div_mask = (6'h01 << clock_divide_select) - 6'h01;
   // Code 7 has no output, so the counter sees no ticks
   assign tick = ~halt & ~clear & (clock_divide_select != `DIV_SEL_NONE) &&
      ((div_count & div_mask) == div_mask);

   // Free divide counter, held while halted, zeroed by a counter clear
   always @(posedge sys_clk)
   begin
      if (rst || clear)
         div_count <= 6'h00;
      else if (!halt)
         div_count <= div_count + 6'h01;
   end
endmodule

// ---- test/pwm_load.sv ----
// Load on the primary pin that times each pulse and each period
`timescale 1ns/1ps
module pwm_load
(
   input wire sys_clk,
   input wire pin_out,
   input wire pin_oe,
   output int high_cnt,
   output int period_cnt,
   output int periods
);
   int hi = 0;
   int since = 0;
   reg prev = 1'b0;
   // A pull-down keeps an undriven pin low, so a released pin never reads as a pulse
   wire lvl = pin_oe & pin_out;
   initial
   begin
      high_cnt = 0;
      period_cnt = 0;
      periods = 0;
   end
   // Each rising edge closes one period and opens the next
   always @(posedge sys_clk)
   begin
      prev <= lvl;
      since <= since + 1;
      hi <= hi + lvl;
      if (lvl && !prev)
      begin
         high_cnt <= hi;
         period_cnt <= since;
         periods <= periods + 1;
         since <= 1;
         hi <= 1;
      end
   end
endmodule

// ---- test/pwm_timer_monitor.sv ----
// Assertion checker on the PWM timer ports
`timescale 1ns/1ps
`include "pwm_timer_defs.vh"
module pwm_timer_monitor
#(
   parameter ADDR_W = 8
)
(
   input wire sys_clk,
   input wire rst,
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire primary_channel_pin_out,
   input wire primary_channel_pin_oe,
   input wire secondary_channel_pin_oe,
   input wire timer_irq
);
   reg [7:0] wa;
   reg [31:0] wd;
   reg bv_q;
   reg link;
   reg halt;
   reg [2:0] ien;
   reg [2:0] quiet;
   wire calm = quiet == 3'h7;
   // Mirror of control bits; it trails the bus, so only quiet spans are judged
   always @(posedge sys_clk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         wa <= s_axi_awaddr[7:0];
      if (s_axi_wvalid && s_axi_wready)
         wd <= s_axi_wdata;
      bv_q <= s_axi_bvalid;
      if (rst || (s_axi_awvalid && s_axi_awready))
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
      if (rst)
      begin
         link <= 1'b0;
         halt <= 1'b1;
         ien <= 3'h0;
      end
      else if (s_axi_bvalid && !bv_q && s_axi_bresp == `RESP_OKAY)
      begin
         if (wa == `OFS_TIMER_CONTROL)
         begin
            halt <= wd[`BIT_COUNTER_HALT];
            ien[0] <= wd[`BIT_WRAP_IRQ_ENABLE];
         end
         if (wa == `OFS_CH0_CONTROL)
         begin
            link <= wd[`BIT_CH_MODE_HI];
            ien[1] <= wd[`BIT_CH_IRQ_ENABLE];
         end
         if (wa == `OFS_CH1_CONTROL)
            ien[2] <= wd[`BIT_CH_IRQ_ENABLE];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read not answered");
   chk_unmapped_read: assert property (rd_taken ##0 (s_axi_araddr >= 8'h20)
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_counter_ro: assert property (wr_taken ##0 (s_axi_awaddr == `OFS_COUNTER)
      |-> ##2 s_axi_bresp == `RESP_SLVERR)
      else $error("counter write accepted");
   chk_link_release: assert property (calm && link |-> !secondary_channel_pin_oe)
      else $error("secondary pin driven while linked");
   chk_link_primary: assert property (calm && link |-> primary_channel_pin_oe)
      else $error("primary pin undriven while linked");
   chk_irq_gated: assert property (calm && ien == 3'h0 |-> !timer_irq)
      else $error("interrupt without enable");
   chk_halt_pin: assert property (calm && halt |=> $stable(primary_channel_pin_out))
      else $error("pin moved while halted");
endmodule
bind timer_buffered_compare_pwm pwm_timer_monitor #(.ADDR_W(ADDR_W)) u_monitor (.sys_clk,
   .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .primary_channel_pin_out, .primary_channel_pin_oe,
   .secondary_channel_pin_oe, .timer_irq);

// ---- test/test_timer_buffered_compare_pwm.sv ----
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ps
`include "pwm_timer_defs.vh"
module test_timer_buffered_compare_pwm;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] awa = 8'h00;
   reg awv = 1'b0;
   reg [31:0] wd = 32'h0;
   reg wv = 1'b0;
   reg br = 1'b0;
   reg [7:0] ara = 8'h00;
   reg arv = 1'b0;
   reg rr = 1'b0;
   wire awr, wrdy, bv, arr, rv, p0, p0e, p1, p1e, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int high_cnt, period_cnt, periods;
   int error_cnt = 0;
   int checks = 0;
   reg [31:0] rd_q;
   reg [1:0] resp_q;
   reg [7:0] seed = 8'h3C;
   timer_buffered_compare_pwm u_dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .primary_channel_pin_out(p0), .primary_channel_pin_oe(p0e),
      .secondary_channel_pin_out(p1), .secondary_channel_pin_oe(p1e), .timer_irq(irq));
   pwm_load u_load (.sys_clk(sys_clk), .pin_out(p0), .pin_oe(p0e), .high_cnt(high_cnt),
      .period_cnt(period_cnt), .periods(periods));
   initial
      forever #20 sys_clk = ~sys_clk;
   function automatic [7:0] lfsr(input [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic [31:0] exp_high(input [15:0] c, input [2:0] s);
      exp_high = {16'h0, c} << s;
   endfunction
   function automatic [31:0] exp_per(input [7:0] l, input [2:0] s);
      exp_per = ({24'h0, l} + 32'd1) << s;
   endfunction
   task automatic chk(input [31:0] got, input [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Address and data are offered together; each drops when its own ready is seen
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awr)
            awv <= 1'b0;
         if (wrdy)
            wv <= 1'b0;
      end
      while ((awv && !awr) || (wv && !wrdy));
      do
         @(posedge sys_clk);
      while (!bv);
      resp_q = bresp;
      br <= 1'b0;
   endtask
   task automatic rd(input [7:0] a);
      @(posedge sys_clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do
         @(posedge sys_clk);
      while (!arr);
      arv <= 1'b0;
      do
         @(posedge sys_clk);
      while (!rv);
      rd_q = rdata;
      resp_q = rresp;
      rr <= 1'b0;
   endtask
   // Halt and clear first so no compare is missed while values change
   task automatic setup(input [2:0] sel, input [7:0] lim, input [15:0] cmp, input [7:0] ctl);
      wr(`OFS_TIMER_CONTROL, 32'h30);
      wr(`OFS_PERIOD_HIGH, 32'h0);
      wr(`OFS_PERIOD_LOW, {24'h0, lim});
      wr(`OFS_CH0_COMPARE, {16'h0, cmp});
      wr(`OFS_CH0_CONTROL, {24'h0, ctl});
      wr(`OFS_TIMER_CONTROL, {29'h0, sel});
   endtask
   // Skip two periods so a value taken at a wrap is judged over a whole period
   task automatic measure(input [31:0] hi, input [31:0] per);
      int p;
      p = periods;
      wait (periods == p + 3);
      @(negedge sys_clk);
      chk(high_cnt, hi);
      chk(period_cnt, per);
   endtask
   task automatic level(input lvl);
      int n;
      n = 0;
      repeat (40)
         @(posedge sys_clk);
      repeat (64)
      begin
         @(negedge sys_clk);
         if (p0 !== lvl)
            n++;
      end
      chk(n, 0);
   endtask
   initial
   begin
      #(40 * 60000);
      error_cnt++;
      final_report;
   end
   initial
   begin
      int p;
      reg [15:0] cmp;
      repeat (6)
         @(posedge sys_clk);
      rst <= 1'b0;
      rd(`OFS_TIMER_CONTROL);
      chk(rd_q, 32'h20);
      rd(8'h20);
      wr(`OFS_COUNTER, 32'h5);
      setup(3'h0, 8'hFF, 16'h80, 8'h1A);
      measure(32'd128, 32'd256);
      wr(`OFS_TIMER_CONTROL, 32'h30);
      rd(`OFS_COUNTER);
      chk(rd_q, 32'h0);
      wr(`OFS_TIMER_CONTROL, 32'h60);
      chk(irq, 1);
      rd(`OFS_TIMER_CONTROL);
      chk(rd_q, 32'hE0);
      wr(`OFS_TIMER_CONTROL, 32'h60);
      chk(irq, 0);
      // High byte alone leaves the flag quiet over two wraps; the low byte re-arms it
      wr(`OFS_PERIOD_HIGH, 32'h0);
      wr(`OFS_TIMER_CONTROL, 32'h40);
      repeat (600)
         @(posedge sys_clk);
      chk(irq, 0);
      wr(`OFS_PERIOD_LOW, 32'hFF);
      repeat (300)
         @(posedge sys_clk);
      chk(irq, 1);
      for (int s = 0; s < 8; s++)
      begin
         seed = lfsr(seed);
         cmp = {8'h00, seed % 8'd15} + 16'd1;
         setup(s[2:0], 8'h0F, cmp, 8'h1A);
         p = periods;
         if (s == 7)
         begin
            repeat (300)
               @(posedge sys_clk);
            chk(periods, p);
         end
         else
            measure(exp_high(cmp, s[2:0]), exp_per(8'h0F, s[2:0]));
      end
      setup(3'h0, 8'h0F, 16'h5, 8'h18);
      level(1'b0);
      setup(3'h0, 8'h0F, 16'h5, 8'h1B);
      level(1'b1);
      // Active-low pulse: set on compare, so the pin is high from match to wrap
      setup(3'h0, 8'h0F, 16'h5, 8'h1E);
      measure(32'd16 - 32'd5, 32'd16);
      // Unbuffered updates: shorter after the compare, longer after the wrap
      setup(3'h0, 8'h0F, 16'h8, 8'h1A);
      @(negedge p0);
      wr(`OFS_CH0_COMPARE, 32'h3);
      measure(exp_high(16'h3, 3'h0), 32'd16);
      @(posedge p0);
      wr(`OFS_CH0_COMPARE, 32'hC);
      measure(exp_high(16'hC, 3'h0), 32'd16);
      // Drive the secondary pin first so its release under the link is visible
      wr(`OFS_CH1_CONTROL, 32'h1B);
      @(posedge sys_clk);
      chk(p1, 1);
      chk(p1e, 1);
      setup(3'h0, 8'h0F, 16'h4, 8'h6A);
      measure(exp_high(16'h4, 3'h0), 32'd16);
      chk(p1e, 0);
      rd(`OFS_CH0_CONTROL);
      chk(rd_q[7], 1);
      seed = lfsr(seed);
      cmp = {8'h00, seed % 8'd15} + 16'd1;
      wr(`OFS_CH1_COMPARE, {16'h0, cmp});
      measure(exp_high(cmp, 3'h0), 32'd16);
      wr(`OFS_CH0_COMPARE, 32'h6);
      measure(exp_high(16'h6, 3'h0), 32'd16);
      final_report;
   end
endmodule
